//--- core/aoc_top.sv
`timescale 1ns/1ps
module aoc_top
    import aoc_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic externalTriggerPin,
    input wire logic [RES_W-1:0] convResult,
    output logic convActive,
    output logic [2:0] inputChan,
    output logic [1:0] inputBank,
    output logic [1:0] inputExt,
    output logic irq
);
    localparam int CNT_W = $clog2(CONV_CYCLES);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);

    function automatic logic [2:0] resultIdx(input logic [2:0] chan, input logic [1:0] ext);
        logic [2:0] idx;
        idx = chan;
        if (ext == EXT_IN0) begin
            idx = 3'h0;
        end else if (ext == EXT_IN1) begin
            idx = 3'h1;
        end
        return idx;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic awHeld_reg, wHeld_reg, bvalid_reg, rvalid_reg;
    logic [IDX_W-1:0] awIdx_reg;
    logic [7:0] wData_reg;
    logic wLane0_reg;
    logic [31:0] rdata_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [7:0] ctrlA_reg, ctrlB_reg, ctrlC_reg;
    logic [ST_W-1:0] status_reg, mask_reg;
    logic busy_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [2:0] resIdx_reg, selChan_reg;
    logic [1:0] selBank_reg, selExt_reg;
    logic trigMeta_reg, trigSync_reg, trigPrev_reg;
    logic [RES_W-1:0] results_reg [8];

    wire doWrite = awHeld_reg & wHeld_reg & ~bvalid_reg;
    wire wrA = doWrite & wLane0_reg & (awIdx_reg == IDX_CTRL_A);
    wire wrB = doWrite & wLane0_reg & (awIdx_reg == IDX_CTRL_B);
    wire wrC = doWrite & wLane0_reg & (awIdx_reg == IDX_CTRL_C);
    wire wrSt = doWrite & wLane0_reg & (awIdx_reg == IDX_STATUS);
    wire wrMk = doWrite & wLane0_reg & (awIdx_reg == IDX_MASK);
    wire wrRes = awIdx_reg[IDX_W-1:3] == IDX_RES_BASE[IDX_W-1:3];
    wire wrMapped = (awIdx_reg == IDX_CTRL_A) | (awIdx_reg == IDX_CTRL_B)
        | (awIdx_reg == IDX_CTRL_C) | (awIdx_reg == IDX_STATUS) | (awIdx_reg == IDX_MASK)
        | wrRes;

    assign s_axi_awready = ~awHeld_reg;
    assign s_axi_wready = ~wHeld_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            awIdx_reg <= '0;
            wData_reg <= 8'h00;
            wLane0_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid & ~awHeld_reg) begin
                awHeld_reg <= 1'b1;
                awIdx_reg <= s_axi_awaddr[AXI_ADDR_W-1:2];
            end else if (doWrite) begin
                awHeld_reg <= 1'b0;
            end
            if (s_axi_wvalid & ~wHeld_reg) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata[7:0];
                wLane0_reg <= s_axi_wstrb[0];
            end else if (doWrite) begin
                wHeld_reg <= 1'b0;
            end
            if (doWrite) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read path; the sweep bits read back but steer nothing.
    wire [IDX_W-1:0] arIdx = s_axi_araddr[AXI_ADDR_W-1:2];
    wire rdRes = arIdx[IDX_W-1:3] == IDX_RES_BASE[IDX_W-1:3];
    wire [7:0] ctrlBRead = ctrlB_reg & ~(8'h01 << B_NOSTORE_BIT);
    wire [31:0] rdMux =
        (arIdx == IDX_CTRL_A) ? {24'h000000, ctrlA_reg} :
        (arIdx == IDX_CTRL_B) ? {24'h000000, ctrlBRead} :
        (arIdx == IDX_CTRL_C) ? {24'h000000, ctrlC_reg} :
        (arIdx == IDX_STATUS) ? {30'h00000000, status_reg} :
        (arIdx == IDX_MASK) ? {30'h00000000, mask_reg} :
        rdRes ? {{(32-RES_W){1'b0}}, results_reg[arIdx[2:0]]} : 32'h00000000;
    wire rdMapped = (arIdx == IDX_CTRL_A) | (arIdx == IDX_CTRL_B) | (arIdx == IDX_CTRL_C)
        | (arIdx == IDX_STATUS) | (arIdx == IDX_MASK) | rdRes;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid & ~rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rdMux;
            rresp_reg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // The pin is sampled twice before the edge detector sees it.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trigMeta_reg <= TRIG_IDLE;
            trigSync_reg <= TRIG_IDLE;
            trigPrev_reg <= TRIG_IDLE;
        end else begin
            trigMeta_reg <= externalTriggerPin;
            trigSync_reg <= trigMeta_reg;
            trigPrev_reg <= trigSync_reg;
        end
    end
    wire trigFall = trigPrev_reg & ~trigSync_reg;

    ////////////////////////////////////////////////////////////////////////////////
    wire swGoSet = wrA & wData_reg[A_GO_BIT];
    wire swGoClr = wrA & ~wData_reg[A_GO_BIT];
    wire [7:0] ctrlAWr = wrA ? wData_reg : ctrlA_reg;
    // Conversions run only in one-shot mode with the converter enabled.
    wire modeOk = (ctrlAWr[A_MODE_LSB+:2] == MODE_ONE_SHOT) & ~ctrlB_reg[B_EXTRA_BIT]
        & ctrlB_reg[B_STBY_BIT];
    wire startSw = swGoSet & ~ctrlAWr[A_TRIG_BIT] & modeOk;
    wire startTrig = ctrlA_reg[A_GO_BIT] & ctrlA_reg[A_TRIG_BIT] & trigFall
        & modeOk & ~swGoClr;
    wire start = startSw | startTrig;
    wire done = busy_reg & (cnt_reg == '0) & ~start;
    wire abort = busy_reg & swGoClr;
    // A software set in the completion cycle wins over the self clear.
    wire goNext = swGoSet | (ctrlA_reg[A_GO_BIT] & ~swGoClr & ~done);
    wire [7:0] ctrlANext = {ctrlAWr[7], goNext, ctrlAWr[5:0]};
    wire [2:0] chanNext = ctrlAWr[A_CHAN_LSB+:3];
    wire [1:0] extNext = ctrlB_reg[B_EXT_LSB+:2];
    wire [ST_W-1:0] stEvents = {abort, done};
    wire [ST_W-1:0] stClear = wrSt ? wData_reg[ST_W-1:0] : '0;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrlA_reg <= CTRL_A_RST;
            ctrlB_reg <= CTRL_B_RST;
            ctrlC_reg <= CTRL_C_RST;
            status_reg <= ST_RST;
            mask_reg <= ST_RST;
        end else begin
            ctrlA_reg <= ctrlANext;
            if (wrB) begin
                ctrlB_reg <= wData_reg & ~(8'h01 << B_NOSTORE_BIT);
            end
            if (wrC) begin
                ctrlC_reg <= wData_reg;
            end
            status_reg <= (status_reg & ~stClear) | stEvents;
            if (wrMk) begin
                mask_reg <= wData_reg[ST_W-1:0];
            end
        end
    end

    // A restart reloads the count, so a retriggered conversion still runs full length.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
            selChan_reg <= 3'h0;
            selBank_reg <= 2'h0;
            selExt_reg <= EXT_NONE;
            resIdx_reg <= 3'h0;
        end else if (start) begin
            busy_reg <= 1'b1;
            cnt_reg <= CNT_LAST;
            selChan_reg <= chanNext;
            selBank_reg <= ctrlC_reg[C_BANK_LSB+:2];
            selExt_reg <= extNext;
            resIdx_reg <= resultIdx(chanNext, extNext);
        end else if (done | abort) begin
            busy_reg <= 1'b0;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - CNT_W'(1);
        end
    end

    for (genvar i = 0; i < 8; i++) begin : g_res
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                results_reg[i] <= '0;
            end else if (done & (resIdx_reg == 3'(i))) begin
                results_reg[i] <= convResult;
            end
        end
    end

    assign convActive = busy_reg;
    assign inputChan = selChan_reg;
    assign inputBank = selBank_reg;
    assign inputExt = selExt_reg;
    assign irq = |(status_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Helper count for the length check; a restart clears it, so a retrigger is measured whole.
    localparam int CONV_LEN = CONV_CYCLES - 1;
    logic [7:0] lenCnt_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lenCnt_reg <= 8'h00;
        end else if (start) begin
            lenCnt_reg <= 8'h00;
        end else if (busy_reg) begin
            lenCnt_reg <= lenCnt_reg + 8'h01;
        end
    end

    a_conv_length: assert property (@(posedge clk_sys) disable iff (rst)
        done |-> lenCnt_reg == 8'(CONV_LEN))
        else $error("Conversion ended before its full cycle count.");
    a_sw_start: assert property (@(posedge clk_sys) disable iff (rst)
        startSw |=> busy_reg && cnt_reg == CNT_LAST)
        else $error("Software start did not begin a conversion.");
    a_trig_cause: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(busy_reg) && !$past(swGoSet) |-> $past(trigFall) && $past(ctrlA_reg[A_GO_BIT]))
        else $error("Conversion began without an armed trigger edge.");
    a_go_self_clear: assert property (@(posedge clk_sys) disable iff (rst)
        done && !swGoSet |=> !ctrlA_reg[A_GO_BIT] && !busy_reg)
        else $error("Go flag not cleared on completion.");
    a_abort_stops: assert property (@(posedge clk_sys) disable iff (rst)
        abort |=> !busy_reg ##1 !busy_reg || $past(start))
        else $error("Abort did not stop the conversion.");
    a_one_shot_stop: assert property (@(posedge clk_sys) disable iff (rst)
        done ##1 (!start)[*3] |-> !busy_reg)
        else $error("Converter kept running after one conversion.");
    a_done_irq: assert property (@(posedge clk_sys) disable iff (rst)
        done && mask_reg[ST_DONE_BIT] |=> irq && status_reg[ST_DONE_BIT])
        else $error("Completion did not raise the interrupt.");
    a_result_store: assert property (@(posedge clk_sys) disable iff (rst)
        done |=> results_reg[$past(resIdx_reg)] == $past(convResult))
        else $error("Result not stored in the matching register.");
    a_input_select: assert property (@(posedge clk_sys) disable iff (rst)
        start |=> inputChan == $past(chanNext) && inputBank == $past(ctrlC_reg[1:0]))
        else $error("Selected input does not follow the control fields.");
    a_retrigger: assert property (@(posedge clk_sys) disable iff (rst)
        busy_reg && startTrig |=> busy_reg && cnt_reg == CNT_LAST)
        else $error("Trigger edge did not restart the conversion.");
    a_sync_edge: assert property (@(posedge clk_sys) disable iff (rst)
        trigFall |-> !$past(externalTriggerPin, 2) && $past(externalTriggerPin, 3))
        else $error("Trigger edge not derived from two synchronised samples.");
    a_ext_select: assert property (@(posedge clk_sys) disable iff (rst)
        start |=> inputExt == $past(extNext))
        else $error("Extended input selection not latched at start.");
    a_ext_result: assert property (@(posedge clk_sys) disable iff (rst)
        busy_reg && (selExt_reg == EXT_IN0 || selExt_reg == EXT_IN1)
            |-> resIdx_reg == {2'h0, selExt_reg[1]})
        else $error("Extended input result routed to the wrong register.");
    a_prim_result: assert property (@(posedge clk_sys) disable iff (rst)
        busy_reg && selExt_reg == EXT_NONE |-> resIdx_reg == selChan_reg)
        else $error("Primary input result routed to the wrong register.");
    a_select_hold: assert property (@(posedge clk_sys) disable iff (rst)
        busy_reg && !start |=> $stable(inputChan) && $stable(inputBank))
        else $error("Input selection changed during a conversion.");
    a_mode_gate: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(busy_reg) |-> ctrlA_reg[A_MODE_LSB+:2] == MODE_ONE_SHOT
            && $past(ctrlB_reg[B_STBY_BIT]) && !$past(ctrlB_reg[B_EXTRA_BIT]))
        else $error("Conversion began outside enabled one-shot mode.");
    a_idle_hold: assert property (@(posedge clk_sys) disable iff (rst)
        !busy_reg && !start |=> !busy_reg)
        else $error("Converter started with no start condition.");
    a_nostore_read: assert property (@(posedge clk_sys) disable iff (rst)
        s_axi_arvalid && s_axi_arready && arIdx == IDX_CTRL_B
            |=> !s_axi_rdata[B_NOSTORE_BIT])
        else $error("Bit without storage read back as one.");
    a_irq_clear: assert property (@(posedge clk_sys) disable iff (rst)
        wrSt && wData_reg[ST_DONE_BIT] && !done |=> !status_reg[ST_DONE_BIT])
        else $error("Done status not cleared by a write of one.");
    a_abort_flag: assert property (@(posedge clk_sys) disable iff (rst)
        abort |=> status_reg[ST_ABORT_BIT] && !ctrlA_reg[A_GO_BIT])
        else $error("Abort did not flag status and clear the go flag.");


    c_sw_conv: cover property (@(posedge clk_sys) disable iff (rst) startSw ##[1:60] done);
    c_trig_conv: cover property (@(posedge clk_sys) disable iff (rst) startTrig ##[1:60] done);
    c_abort: cover property (@(posedge clk_sys) disable iff (rst) abort);
    c_retrig: cover property (@(posedge clk_sys) disable iff (rst) busy_reg && startTrig);
    c_ext_conv: cover property (@(posedge clk_sys) disable iff (rst) start && extNext != EXT_NONE);
endmodule

//--- dv/aoc_front_model.sv
`timescale 1ns/1ps
module aoc_front_model
    import aoc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic convActive,
    input wire logic [2:0] inputChan,
    input wire logic [1:0] inputBank,
    input wire logic [1:0] inputExt,
    output logic externalTriggerPin,
    output logic [9:0] convResult
);
    logic [9:0] junk = 10'h2AA;
    // Outside a conversion the code churns between 2AA and 155, so a late sample matches only for bank 1, ext 1, chan 2.
    always @(posedge clk_sys) junk <= ~junk;
    assign convResult = convActive ? {inputBank, inputExt, inputChan, 3'h5} : junk;
    // The pin falls off the clock grid and stays low for four cycles.
    initial begin
        externalTriggerPin = TRIG_IDLE;
        forever begin
            @(posedge fire);
            #37 externalTriggerPin = 1'h0;
            #400 externalTriggerPin = TRIG_IDLE;
        end
    end
endmodule

//--- dv/test_adc_one_shot_control.sv
`timescale 1ns/1ps
module test_adc_one_shot_control
    import aoc_pkg::*;
;
    typedef struct {string nm; logic [31:0] d; logic [1:0] r;} aoc_exp_t;
    logic clk_sys, rst, fire, externalTriggerPin, convActive, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, inputBank, inputExt, bk, sw;
    logic [2:0] inputChan;
    logic [9:0] convResult;
    logic [9:0] regIdx[5] = '{IDX_CTRL_A, IDX_CTRL_B, IDX_CTRL_C, IDX_STATUS, IDX_MASK};
    int errCount = 0;
    int compares = 0;
    integer seed = 32'h6042;
    aoc_exp_t expQ[$];
    aoc_exp_t e;
    logic [1:0] bQ[$];

    aoc_top #(.RES_W(10)) aoc_top_inst (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .externalTriggerPin, .convResult, .convActive, .inputChan, .inputBank,
        .inputExt, .irq);
    aoc_front_model aoc_front_model_inst (.clk_sys, .fire, .convActive, .inputChan,
        .inputBank, .inputExt, .externalTriggerPin, .convResult);

    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic testDone();
        $display("compares %0d errors %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                      input logic [1:0] r = RESP_OKAY);
        bQ.push_back(r);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'($random(seed)), d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
    endtask

    task automatic rd(input string nm, input logic [9:0] idx, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        expQ.push_back('{nm, d, r});
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
    endtask

    task automatic quiet(input string nm);
        repeat (5) @(posedge clk_sys);
        check(nm, 34'(convActive), 34'h0);
    endtask

    // A retrigger at cycle retrig must stretch the run past one full conversion.
    task automatic conv(input logic [2:0] ch, input logic [1:0] b, input logic [1:0] ex,
                        input logic trigger_source_sel, input int retrig, input logic im);
        int n;
        logic [2:0] ri;
        n = 0;
        ri = (ex == EXT_IN0) ? 3'h0 : (ex == EXT_IN1) ? 3'h1 : ch;
        while (!convActive) @(posedge clk_sys);
        check("chan", 34'(inputChan), 34'(ch));
        check("bank", 34'(inputBank), 34'(b));
        check("ext", 34'(inputExt), 34'(ex));
        while (convActive) begin
            n++;
            fire <= (n == retrig);
            @(posedge clk_sys);
        end
        if (retrig == 0) check("cycles", 34'(n), 34'(CONV_CYCLES));
        else check("restart", 34'(n > CONV_CYCLES + retrig), 34'h1);
        quiet("oneShot");
        rd("result", IDX_RES_BASE + 10'(ri), {22'h0, b, ex, ch, 3'h5});
        rd("goClear", IDX_CTRL_A, {26'h0, trigger_source_sel, 2'h0, ch});
        rd("status", IDX_STATUS, 32'h1);
        check("irq", 34'(irq), 34'(im));
        wr(IDX_STATUS, 8'h01);
        @(posedge clk_sys);
        check("irqClr", 34'(irq), 34'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready && expQ.size() > 0) begin
            e = expQ.pop_front();
            check(e.nm, {s_axi_rresp, s_axi_rdata}, {e.r, e.d});
        end
        if (s_axi_bvalid && s_axi_bready && bQ.size() > 0) begin
            check("bresp", 34'(s_axi_bresp), 34'(bQ.pop_front()));
        end
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        errCount++;
        testDone();
    end

    initial begin
        rst = 1'h1;
        fire = 1'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'h1;
        s_axi_rready = 1'h1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        for (int i = 0; i < 5; i++) rd("resetVal", regIdx[i], 32'h0);
        rd("unmapped", 10'h3FF, 32'h0, RESP_SLVERR);
        wr(10'h3FF, 8'h5A, RESP_SLVERR);
        s_axi_wstrb <= 4'hE;
        wr(IDX_CTRL_C, 8'hFF);
        s_axi_wstrb <= 4'hF;
        rd("laneOff", IDX_CTRL_C, 32'h0);
        wr(IDX_MASK, 8'h03);
        wr(IDX_CTRL_A, 8'h40);
        quiet("standbyOff");
        wr(IDX_CTRL_B, 8'h28);
        rd("noStore", IDX_CTRL_B, 32'h20);
        wr(IDX_CTRL_A, 8'h48);
        quiet("modeRepeat");
        wr(IDX_CTRL_B, 8'h24);
        wr(IDX_CTRL_A, 8'h40);
        quiet("extraMode");
        wr(IDX_CTRL_A, 8'h00);
        for (int i = 0; i < 10; i++) begin
            bk = 2'($unsigned($random(seed)) % 3);
            sw = 2'($random(seed));
            wr(IDX_CTRL_C, {6'h0, bk});
            wr(IDX_CTRL_B, {(i < 8) ? EXT_NONE : 2'(i - 7), 4'h8, sw});
            wr(IDX_CTRL_A, {5'h08, 3'(i)});
            conv(3'(i), bk, (i < 8) ? EXT_NONE : 2'(i - 7), 1'h0, 0, 1'h1);
        end
        wr(IDX_CTRL_B, 8'h20);
        wr(IDX_CTRL_A, 8'h45);
        wr(IDX_CTRL_A, 8'h05);
        quiet("abort");
        rd("abortSt", IDX_STATUS, 32'h2);
        check("abortIrq", 34'(irq), 34'h1);
        wr(IDX_STATUS, 8'h02);
        wr(IDX_CTRL_A, 8'h26);
        fire <= 1'h1;
        @(posedge clk_sys);
        fire <= 1'h0;
        quiet("pinNoGo");
        wr(IDX_CTRL_A, 8'h66);
        quiet("pinWait");
        fire <= 1'h1;
        @(posedge clk_sys);
        fire <= 1'h0;
        conv(3'h6, bk, EXT_NONE, 1'h1, 0, 1'h1);
        wr(IDX_CTRL_A, 8'h66);
        fire <= 1'h1;
        @(posedge clk_sys);
        fire <= 1'h0;
        conv(3'h6, bk, EXT_NONE, 1'h1, 10, 1'h1);
        wr(IDX_MASK, 8'h00);
        wr(IDX_CTRL_A, 8'h41);
        conv(3'h1, bk, EXT_NONE, 1'h0, 0, 1'h0);
        testDone();
    end
endmodule

//--- inc/aoc_pkg.sv
package aoc_pkg;
    localparam int AXI_ADDR_W = 12;
    localparam int IDX_W = 10;
    // Register indices; byte address is four times the index.
    localparam logic [9:0] IDX_CTRL_A = 10'h3D6;
    localparam logic [9:0] IDX_CTRL_B = 10'h3D7;
    localparam logic [9:0] IDX_CTRL_C = 10'h3D8;
    localparam logic [9:0] IDX_STATUS = 10'h3D9;
    localparam logic [9:0] IDX_MASK = 10'h3DA;
    localparam logic [9:0] IDX_RES_BASE = 10'h3C0;
    // Control A fields.
    localparam int A_CHAN_LSB = 0;
    localparam int A_MODE_LSB = 3;
    localparam int A_TRIG_BIT = 5;
    localparam int A_GO_BIT = 6;
    // Control B fields.
    localparam int B_EXTRA_BIT = 2;
    localparam int B_NOSTORE_BIT = 3;
    localparam int B_STBY_BIT = 5;
    localparam int B_EXT_LSB = 6;
    // Control C fields.
    localparam int C_BANK_LSB = 0;
    // Status and mask fields.
    localparam int ST_DONE_BIT = 0;
    localparam int ST_ABORT_BIT = 1;
    localparam int ST_W = 2;
    // Values after reset.
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] CTRL_C_RST = 8'h00;
    localparam logic [1:0] ST_RST = 2'h0;
    localparam logic [1:0] MODE_ONE_SHOT = 2'h0;
    localparam logic [1:0] EXT_NONE = 2'h0;
    localparam logic [1:0] EXT_IN0 = 2'h1;
    localparam logic [1:0] EXT_IN1 = 2'h2;
    localparam logic TRIG_IDLE = 1'b1;
    // Converter clock cycles per conversion.
    localparam int CONV_CYCLES = 43;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
